// ### locator_burst_scheduler.sv
// Transmit burst scheduler with test patterns, carrier mode and timing edge
// Functional notes
// [R1] Random first slot sets whole schedule
// [R2] Other seven slots fixed from first
// [R3] Seventy-five slots between burst transmissions
// [R4] Transmissions alternate primary and secondary channel
// [R5] First active burst carries time-out seven
// [R6] Time-out decrements per burst afterwards
// [R7] Every slot is a selection candidate
// [R8] Expiry picks random next-set offset
// [R9] One time-out value per burst
// [R10] Safety text fifth, sixth at seven, three
// [R11] Safety text alternates between channels
// [R12] Test burst: time-out and sub-message zero
// [R13] Test safety text first and eighth
// [R14] Pattern one: raw alternating bits
// [R15] Pattern two: raw four zeros, ones
// [R16] Pattern three: raw 511-bit sequence
// [R17] Edge marks each timing reference instant
// [R18] Selectable unmodulated continuous carrier
// [R19] Ramp up before, down after frame
// [R20] No lock in five minutes: abandon
// [R21] Test activation clears after burst
// [R22] Lost fix keeps last good position
// [R23] Slot arithmetic wraps at frame length
`timescale 1ns/1ns
module locator_burst_scheduler import locator_pkg::*; #(
	parameter int POS_W       = 32,
	parameter int FRAME_BITS  = 256,
	parameter int LOCK_SLOTS  = TEST_WAIT_SLOTS
) (
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	// Slot and bit timing from the UTC-derived timer
	input  wire logic             slotTick,
	input  wire logic             frameStart,
	input  wire logic             bitTick,
	// Switches and lock pins
	input  wire logic             activeSwitch,
	input  wire logic             testSwitch,
	input  wire logic             timeLock,
	input  wire logic             unmodCarrierMode,
	// Position source
	input  wire logic             posValid,
	input  wire logic [POS_W-1:0] posIn,
	// Test pattern control
	input  wire logic             patternStart,
	input  wire logic [1:0]       patternSel,
	// Transmission descriptors to the modulator
	output logic                  txValid,
	input  wire logic             txReady,
	output logic                  txChannel,
	output logic                  txSafetyText,
	output logic [2:0]            txSlotTimeout,
	output logic [13:0]           txSubMessage,
	output logic [11:0]           txSlot,
	output logic [POS_W-1:0]      txPosition,
	// Test bit stream
	output logic                  testBit,
	output logic                  testBitValid,
	output logic                  nrziBypass,
	output logic                  rampUp,
	output logic                  rampDown,
	// Status and timing
	output logic                  timingRefEdge,
	output logic                  carrierOn,
	output logic                  modulationOff,
	output logic                  testActive,
	output logic                  testAbandoned
);
	localparam int DW = DESC_FIXED_W + POS_W;

	if (POS_W < 1 || FRAME_BITS < 8 || LOCK_SLOTS < 1 || LOCK_SLOTS >= 16384)
		$error("locator_burst_scheduler: unsupported parameter value");

	sched_state_t      state;
	logic [3:0]        pinMeta;
	logic [3:0]        pinSync;
	logic              activeOn;
	logic              testOn;
	logic              lockOn;
	logic              cwOn;
	logic              testPrev;
	logic              testPending;
	logic [15:0]       lfsr;
	logic [11:0]       slotNow;
	logic [11:0]       firstSlot;
	logic [11:0]       nextSlot;
	logic [2:0]        txIdx;
	logic [2:0]        timeout;
	logic              inTest;
	logic [13:0]       lockCnt;
	logic [POS_W-1:0]  lastPos;
	logic [11:0]       randSlot;
	logic [11:0]       jitter;
	logic [11:0]       setOffset;
	logic [11:0]       offsetHold;
	logic              safetyNow;
	logic [DW-1:0]     desc;
	logic              bufReady;
	logic              pushDesc;
	logic              burstDone;

	function automatic logic [11:0] slot_add(input logic [11:0] a, input logic [11:0] b);
		logic [12:0] s;
		s = {1'b0, a} + {1'b0, b};
		if (s >= {1'b0, FRAME_SLOTS})
			s = s - {1'b0, FRAME_SLOTS};
		return s[11:0];
	endfunction

	// Pins pass two flops; only the second stage is read
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pinMeta <= 4'h0;
			pinSync <= 4'h0;
		end
		else
		begin
			pinMeta <= {unmodCarrierMode, timeLock, testSwitch, activeSwitch};
			pinSync <= pinMeta;
		end
	end
	assign activeOn = pinSync[0];
	assign testOn   = pinSync[1];
	assign lockOn   = pinSync[2];
	assign cwOn     = pinSync[3];

	// Free-running generator; every slot is a candidate, slots up to 1845 twice as likely as the rest
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			lfsr <= RAND_SEED;
		else
			lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
	end
	assign randSlot  = (lfsr[11:0] >= FRAME_SLOTS) ? lfsr[11:0] - FRAME_SLOTS : lfsr[11:0]; // [R7]
	assign jitter    = ({3'h0, lfsr[15:7]} > JITTER_SPAN) ? {3'h0, lfsr[15:7]} - JITTER_SLOTS
		: {3'h0, lfsr[15:7]};
	assign setOffset = slot_add(FRAME_SLOTS - JITTER_SLOTS, jitter); // [R8]

	// Slot position inside the minute frame
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			slotNow <= 12'h000;
		else if (frameStart)
			slotNow <= 12'h000;
		else if (slotTick)
			slotNow <= slot_add(slotNow, 12'h001); // [R23]
	end

	// Position is only replaced by a valid fix
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			lastPos <= '0;
		else if (posValid)
			lastPos <= posIn; // [R22]
	end

	// Test activation is latched on the switch edge
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			testPrev    <= 1'b0;
			testPending <= 1'b0;
		end
		else
		begin
			testPrev <= testOn;
			if (testOn && !testPrev)
				testPending <= 1'b1;
			else if ((state == ST_END && inTest) || (state == ST_LOCK && slotTick && !lockOn
				&& lockCnt == 14'(LOCK_SLOTS - 1)))
				testPending <= 1'b0; // [R21]
		end
	end

	assign safetyNow = inTest ? (txIdx == TEST_SAFETY_A || txIdx == TEST_SAFETY_B) // [R13]
		: ((timeout == STO_FIRST || timeout == STO_SAFETY_LATE)
		&& (txIdx == ACT_SAFETY_A || txIdx == ACT_SAFETY_B)); // [R10]
	assign desc = {txIdx[0] ? CH_SECONDARY : CH_PRIMARY, // [R4] [R11]
		safetyNow ? MSG_SAFETY : MSG_POSITION,
		timeout,
		inTest ? SUBMSG_TEST : ((timeout == STO_EXPIRED) ? {2'h0, offsetHold} : {2'h0, nextSlot}),
		nextSlot, lastPos};
	assign pushDesc  = (state == ST_ISSUE) && bufReady;
	assign burstDone = pushDesc && (txIdx == LAST_TX);

	// Scheduler sequence
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			state <= ST_IDLE;
		else
		begin
			unique case (state)
				ST_IDLE:
					if (testPending)
						state <= ST_LOCK;
					else if (activeOn)
						state <= ST_PICK;
				ST_LOCK:
					if (lockOn)
						state <= ST_PICK;
					else if (slotTick && lockCnt == 14'(LOCK_SLOTS - 1))
						state <= ST_IDLE; // [R20]
				ST_PICK:
					state <= ST_WAIT;
				ST_WAIT:
					if (!inTest && !activeOn)
						state <= ST_IDLE;
					else if (slotTick && slotNow == nextSlot)
						state <= ST_ISSUE;
				ST_ISSUE:
					if (burstDone)
						state <= ST_END;
					else if (pushDesc)
						state <= ST_WAIT;
				ST_END:
					state <= inTest ? ST_IDLE : ST_WAIT;
				default:
					state <= ST_IDLE;
			endcase
		end
	end

	// Slot plan, burst index and time-out
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			firstSlot <= 12'h000;
			nextSlot  <= 12'h000;
			txIdx     <= 3'h0;
			timeout   <= STO_FIRST;
			inTest    <= 1'b0;
			offsetHold <= 12'h000;
		end
		else if (state == ST_IDLE)
			inTest <= testPending;
		else if (state == ST_PICK)
		begin
			offsetHold <= setOffset; // [R8]
			firstSlot <= randSlot; // [R1]
			nextSlot  <= randSlot;
			txIdx     <= 3'h0;
			timeout   <= inTest ? STO_EXPIRED : STO_FIRST; // [R5] [R12]
		end
		else if (pushDesc)
		begin
			txIdx    <= txIdx + 3'h1;
			nextSlot <= slot_add(nextSlot, SLOT_STEP); // [R2] [R3] [R23]
		end
		else if (state == ST_END && !inTest)
		begin
			// Time-out only moves between bursts
			if (timeout == STO_EXPIRED)
			begin
				firstSlot <= slot_add(firstSlot, offsetHold); // [R8]
				nextSlot  <= slot_add(firstSlot, offsetHold);
				timeout   <= STO_FIRST;
			end
			else
			begin
				// Offset is frozen a burst early so the expiring burst announces the one really used
				offsetHold <= setOffset; // [R8]
				nextSlot <= firstSlot;
				timeout  <= timeout - 3'h1; // [R6] [R9]
			end
		end
	end

	// Lock wait counted in slots
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			lockCnt       <= 14'h0000;
			testAbandoned <= 1'b0;
		end
		else
		begin
			testAbandoned <= (state == ST_LOCK) && !lockOn && slotTick && lockCnt == 14'(LOCK_SLOTS - 1); // [R20]
			if (state != ST_LOCK)
				lockCnt <= 14'h0000;
			else if (slotTick)
				lockCnt <= lockCnt + 14'h0001;
		end
	end

	two_entry_buffer #(
		.W (DW)
	) u_desc_buf (
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.inValid  (state == ST_ISSUE),
		.inData   (desc),
		.inReady  (bufReady),
		.outValid (txValid),
		.outData  ({txChannel, txSafetyText, txSlotTimeout, txSubMessage, txSlot, txPosition}),
		.outReady (txReady)
	);

	// Test pattern frames
	logic [15:0] bitCnt;
	logic        frameOn;
	logic [1:0]  patReg;
	logic [2:0]  nibCnt;
	logic [8:0]  prbs;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			frameOn      <= 1'b0;
			patReg       <= PAT_NONE;
			bitCnt       <= 16'h0000;
			nibCnt       <= 3'h0;
			prbs         <= PRBS_SEED;
			testBit      <= 1'b0;
			testBitValid <= 1'b0;
			rampUp       <= 1'b0;
			rampDown     <= 1'b0;
		end
		else
		begin
			rampUp       <= 1'b0;
			rampDown     <= 1'b0;
			testBitValid <= 1'b0;
			if (!frameOn && patternStart && patternSel != PAT_NONE)
			begin
				frameOn <= 1'b1;
				patReg  <= patternSel;
				bitCnt  <= 16'h0000;
				nibCnt  <= 3'h0;
				prbs    <= PRBS_SEED;
				rampUp  <= 1'b1; // [R19]
			end
			else if (frameOn && bitTick)
			begin
				testBitValid <= 1'b1;
				nibCnt       <= nibCnt + 3'h1;
				bitCnt       <= bitCnt + 16'h0001;
				unique case (patReg)
					PAT_REVERSALS:
						testBit <= bitCnt[0]; // [R14]
					PAT_NIBBLES:
						testBit <= nibCnt[2]; // [R15]
					default:
					begin
						testBit <= prbs[8]; // [R16]
						prbs    <= {prbs[7:0], prbs[8] ^ prbs[4]};
					end
				endcase
				if (bitCnt == 16'(FRAME_BITS - 1))
				begin
					frameOn  <= 1'b0;
					rampDown <= 1'b1; // [R19]
				end
			end
		end
	end

	// Carrier, reference edge and status
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			carrierOn     <= 1'b0;
			modulationOff <= 1'b0;
			nrziBypass    <= 1'b0;
			timingRefEdge <= 1'b0;
			testActive    <= 1'b0;
		end
		else
		begin
			carrierOn     <= cwOn || frameOn; // [R18]
			modulationOff <= cwOn; // [R18]
			nrziBypass    <= frameOn; // [R14] [R15] [R16]
			timingRefEdge <= pushDesc || (!frameOn && patternStart && patternSel != PAT_NONE); // [R17]
			testActive    <= testPending;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	property p_slot_wrap;
		nextSlot < FRAME_SLOTS && firstSlot < FRAME_SLOTS;
	endproperty
	a_slot_wrap: assert property (p_slot_wrap) else $error("slot index beyond frame"); // [R23]

	property p_step;
		pushDesc && txIdx != LAST_TX |=> nextSlot == slot_add($past(nextSlot), SLOT_STEP);
	endproperty
	a_step: assert property (p_step) else $error("burst spacing wrong"); // [R3]

	property p_channel;
		pushDesc |-> desc[DW-1] == txIdx[0];
	endproperty
	a_channel: assert property (p_channel) else $error("channel not alternating"); // [R4]

	property p_test_fields;
		pushDesc && inTest |-> timeout == STO_EXPIRED && desc[POS_W+25:POS_W+12] == SUBMSG_TEST;
	endproperty
	a_test_fields: assert property (p_test_fields) else $error("test burst fields not zero"); // [R12]

	property p_decrement;
		state == ST_END && !inTest && timeout != STO_EXPIRED |=> timeout == $past(timeout) - 3'h1;
	endproperty
	a_decrement: assert property (p_decrement) else $error("time-out not decremented"); // [R6]

	property p_same_timeout;
		pushDesc && txIdx != LAST_TX |=> $stable(timeout);
	endproperty
	a_same_timeout: assert property (p_same_timeout) else $error("time-out changed inside burst"); // [R9]

	property p_safety;
		pushDesc && !inTest && (timeout == STO_FIRST || timeout == STO_SAFETY_LATE)
			&& (txIdx == ACT_SAFETY_A || txIdx == ACT_SAFETY_B) |-> desc[DW-2] == MSG_SAFETY;
	endproperty
	a_safety: assert property (p_safety) else $error("safety text missing"); // [R10]

	property p_test_safety;
		pushDesc && inTest |-> desc[DW-2] == (txIdx == TEST_SAFETY_A || txIdx == TEST_SAFETY_B);
	endproperty
	a_test_safety: assert property (p_test_safety) else $error("test safety text misplaced"); // [R13]

	property p_test_clear;
		state == ST_END && inTest && !(testOn && !testPrev) |=> !testPending && state == ST_IDLE;
	endproperty
	a_test_clear: assert property (p_test_clear) else $error("test activation not cleared"); // [R21]

	property p_cw;
		cwOn |=> carrierOn && modulationOff;
	endproperty
	a_cw: assert property (p_cw) else $error("carrier mode not applied"); // [R18]

	property p_ramp;
		rampDown |-> ##1 !nrziBypass;
	endproperty
	a_ramp: assert property (p_ramp) else $error("bypass held after frame"); // [R19]
endmodule // locator_burst_scheduler

// ### locator_pkg.sv
// Constants, encodings and state types shared by the burst scheduler files
package locator_pkg;
	// Slot frame: one minute of slots on each channel
	localparam int          SLOTS_PER_MIN    = 2250;
	localparam logic [11:0] FRAME_SLOTS      = 12'h8ca;
	localparam logic [11:0] SLOT_STEP        = 12'h04b;
	localparam logic [2:0]  LAST_TX          = 3'h7;
	// Slot-time-out values
	localparam logic [2:0]  STO_FIRST        = 3'h7;
	localparam logic [2:0]  STO_SAFETY_LATE  = 3'h3;
	localparam logic [2:0]  STO_EXPIRED      = 3'h0;
	localparam logic [13:0] SUBMSG_TEST      = 14'h0000;
	// Safety-text positions inside a burst
	localparam logic [2:0]  ACT_SAFETY_A     = 3'h4;
	localparam logic [2:0]  ACT_SAFETY_B     = 3'h5;
	localparam logic [2:0]  TEST_SAFETY_A    = 3'h0;
	localparam logic [2:0]  TEST_SAFETY_B    = 3'h7;
	// Next-set offset: one minute plus or minus the jitter
	localparam int          OFFSET_JITTER_S  = 6;
	localparam logic [11:0] JITTER_SLOTS     = 12'(OFFSET_JITTER_S * SLOTS_PER_MIN / 60);
	localparam logic [11:0] JITTER_SPAN      = 12'(2 * OFFSET_JITTER_S * SLOTS_PER_MIN / 60);
	// Test mode lock wait
	localparam int          TEST_LOCK_WAIT_S = 300;
	localparam int          TEST_WAIT_SLOTS  = TEST_LOCK_WAIT_S * SLOTS_PER_MIN / 60;
	// Channel and message encodings
	localparam logic        CH_PRIMARY       = 1'b0;
	localparam logic        CH_SECONDARY     = 1'b1;
	localparam logic        MSG_POSITION     = 1'b0;
	localparam logic        MSG_SAFETY       = 1'b1;
	// Test bit patterns
	localparam logic [1:0]  PAT_NONE         = 2'h0;
	localparam logic [1:0]  PAT_REVERSALS    = 2'h1;
	localparam logic [1:0]  PAT_NIBBLES      = 2'h2;
	localparam logic [1:0]  PAT_PRBS         = 2'h3;
	localparam logic [8:0]  PRBS_SEED        = 9'h1ff;
	localparam logic [15:0] RAND_SEED        = 16'hace1;
	localparam int          DESC_FIXED_W     = 1 + 1 + 3 + 14 + 12;

	typedef enum logic [2:0]
	{
		ST_IDLE  = 3'h0,
		ST_PICK  = 3'h1,
		ST_WAIT  = 3'h3,
		ST_ISSUE = 3'h2,
		ST_END   = 3'h6,
		ST_LOCK  = 3'h4
	} sched_state_t;
endpackage

// ### two_entry_buffer.sv
// Two-entry buffer whose outputs come straight from flip-flops
`timescale 1ns/1ns
module two_entry_buffer #(
	parameter int W = 8
) (
	// Clock and reset
	input  wire logic         clk_sys,
	input  wire logic         rst_n,
	// Filling side
	input  wire logic         inValid,
	input  wire logic [W-1:0] inData,
	output logic              inReady,
	// Draining side
	output logic              outValid,
	output logic [W-1:0]      outData,
	input  wire logic         outReady
);
	logic         spareValid;
	logic [W-1:0] spareData;
	logic         push;
	logic         pop;

	assign push    = inValid && !spareValid;
	assign pop     = outValid && outReady;
	assign inReady = !spareValid;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			outValid   <= 1'b0;
			spareValid <= 1'b0;
		end
		else
		begin
			outValid   <= (outValid && !pop) || spareValid || push;
			spareValid <= outValid && !pop && (spareValid || push);
		end
	end

	// Head refills from the spare first so word order is kept
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			outData   <= '0;
			spareData <= '0;
		end
		else
		begin
			if (pop || !outValid)
				outData <= spareValid ? spareData : inData;
			if (push && outValid && !pop)
				spareData <= inData;
		end
	end
endmodule // two_entry_buffer

// ### rx_station_model.sv
// Receiving station model that logs the first 128 descriptors it takes off the air
`timescale 1ns/1ns
module rx_station_model import locator_pkg::*; #(
	parameter int POS_W = 32
) (
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	// Stall control from the bench
	input  wire logic             slow,
	// Descriptor side
	input  wire logic             txValid,
	output logic                  txReady,
	input  wire logic             txChannel,
	input  wire logic             txSafetyText,
	input  wire logic [2:0]       txSlotTimeout,
	input  wire logic [13:0]      txSubMessage,
	input  wire logic [11:0]      txSlot,
	input  wire logic [POS_W-1:0] txPosition,
	// Received count
	output int                    rxCount
);
	logic             logChan [0:127];
	logic             logSafe [0:127];
	logic [2:0]       logSto  [0:127];
	logic [13:0]      logSub  [0:127];
	logic [11:0]      logSlot [0:127];
	logic [POS_W-1:0] logPos  [0:127];
	int               stallCnt;

	// A slow station listens one cycle in four, so the buffer must hold words back
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			txReady  <= 1'b0;
			stallCnt <= 0;
			rxCount  <= 0;
		end
		else
		begin
			stallCnt <= (stallCnt + 1) % 4;
			txReady  <= !slow || stallCnt == 3;
			if (txValid && txReady)
				rxCount <= rxCount + 1;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (txValid && txReady && rxCount < 128)
		begin
			logChan[rxCount] <= txChannel;
			logSafe[rxCount] <= txSafetyText;
			logSto[rxCount]  <= txSlotTimeout;
			logSub[rxCount]  <= txSubMessage;
			logSlot[rxCount] <= txSlot;
			logPos[rxCount]  <= txPosition;
		end
	end
endmodule // rx_station_model

// ### tb.sv
// Self-checking bench for the burst scheduler
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fails++; $display("BAD %s exp %0h got %0h", nm, (e), (g)); end end
module tb import locator_pkg::*;;
	localparam int          FB = 16;
	localparam logic [31:0] P  = 32'h5a3c0f17;
	logic clk_sys = 1'b0, rst_n = 1'b0, slotTick = 1'b0, frameStart = 1'b0, bitTick = 1'b0, tickOn = 1'b0;
	logic activeSwitch = 1'b0, testSwitch = 1'b0, timeLock = 1'b0, unmodCarrierMode = 1'b0, slow = 1'b0;
	logic posValid = 1'b0, patternStart = 1'b0;
	logic [31:0] posIn = 32'h0;
	logic [1:0]  patternSel = 2'h0;
	logic txValid, txReady, txChannel, txSafetyText, testBit, testBitValid, nrziBypass, rampUp, rampDown;
	logic timingRefEdge, carrierOn, modulationOff, testActive, testAbandoned;
	logic [2:0]  txSlotTimeout;
	logic [13:0] txSubMessage;
	logic [11:0] txSlot;
	logic [31:0] txPosition;
	int          rxCount;
	int          fails = 0, checked = 0, refN = 0, upN = 0, dnN = 0, abN = 0, bitN = 0;
	logic        bits [0:63];

	locator_burst_scheduler #(.POS_W(32), .FRAME_BITS(FB), .LOCK_SLOTS(8)) uut (
		.clk_sys(clk_sys), .rst_n(rst_n), .slotTick(slotTick), .frameStart(frameStart), .bitTick(bitTick),
		.activeSwitch(activeSwitch), .testSwitch(testSwitch), .timeLock(timeLock),
		.unmodCarrierMode(unmodCarrierMode), .posValid(posValid), .posIn(posIn), .patternStart(patternStart),
		.patternSel(patternSel), .txValid(txValid), .txReady(txReady), .txChannel(txChannel),
		.txSafetyText(txSafetyText), .txSlotTimeout(txSlotTimeout), .txSubMessage(txSubMessage), .txSlot(txSlot),
		.txPosition(txPosition), .testBit(testBit), .testBitValid(testBitValid), .nrziBypass(nrziBypass),
		.rampUp(rampUp), .rampDown(rampDown), .timingRefEdge(timingRefEdge), .carrierOn(carrierOn),
		.modulationOff(modulationOff), .testActive(testActive), .testAbandoned(testAbandoned));
	rx_station_model #(.POS_W(32)) rx (
		.clk_sys(clk_sys), .rst_n(rst_n), .slow(slow), .txValid(txValid), .txReady(txReady),
		.txChannel(txChannel), .txSafetyText(txSafetyText), .txSlotTimeout(txSlotTimeout),
		.txSubMessage(txSubMessage), .txSlot(txSlot), .txPosition(txPosition), .rxCount(rxCount));

	always #20 clk_sys = !clk_sys;
	// Slot ticks every other cycle keep a ten-minute schedule within the run budget
	always @(negedge clk_sys) slotTick <= tickOn && !slotTick;
	always @(posedge clk_sys)
	begin
		refN += int'(timingRefEdge === 1'b1);
		upN += int'(rampUp === 1'b1);
		dnN += int'(rampDown === 1'b1);
		abN += int'(testAbandoned === 1'b1);
		if (testBitValid === 1'b1 && bitN < 64)
		begin
			bits[bitN] = testBit;
			bitN++;
		end
	end

	task automatic wrap_up();
		if (fails == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic wait_n(int n, int lim);
		int c;
		c = 0;
		while (rxCount < n && c < lim)
		begin
			@(negedge clk_sys);
			c++;
		end
	endtask

	task automatic chk_burst(int j0, int sto, int first, bit test);
		logic s;
		for (int i = 0; i < 8; i++)
		begin
			s = test ? (i == 0 || i == 7) : ((sto == 7 || sto == 3) && (i == 4 || i == 5));
			`CHK("slot", (first + 75 * i) % 2250, rx.logSlot[j0+i])
			`CHK("channel", i % 2, rx.logChan[j0+i])
			`CHK("timeout", sto, rx.logSto[j0+i])
			`CHK("safety", s, rx.logSafe[j0+i])
			if (test)
				`CHK("submsg", 0, rx.logSub[j0+i])
			else if (!s)
				`CHK("position", P, rx.logPos[j0+i])
		end
	endtask

	task automatic run_cw();
		unmodCarrierMode = 1'b1;
		repeat (6) @(negedge clk_sys);
		`CHK("carrierOn", 1, carrierOn)
		`CHK("modulationOff", 1, modulationOff)
		unmodCarrierMode = 1'b0;
		repeat (6) @(negedge clk_sys);
		`CHK("carrierOff", 0, carrierOn)
	endtask

	task automatic run_patterns();
		logic [8:0] s;
		logic       e;
		int         u0, d0, r0;
		for (int sel = 1; sel <= 3; sel++)
		begin
			s = PRBS_SEED;
			u0 = upN;
			d0 = dnN;
			r0 = refN;
			bitN = 0;
			patternSel = 2'(sel);
			patternStart = 1'b1;
			@(negedge clk_sys);
			patternStart = 1'b0;
			repeat (3) @(negedge clk_sys);
			`CHK("bypassOn", 1, nrziBypass)
			for (int k = 0; k < FB; k++)
			begin
				bitTick = 1'b1;
				@(negedge clk_sys);
				bitTick = 1'b0;
				@(negedge clk_sys);
			end
			repeat (3) @(negedge clk_sys);
			`CHK("bitCount", FB, bitN)
			for (int k = 0; k < FB; k++)
			begin
				e = (sel == 1) ? k[0] : (sel == 2) ? k[2] : s[8];
				s = {s[7:0], s[8] ^ s[4]};
				`CHK("bit", e, bits[k])
			end
			`CHK("bypassOff", 0, nrziBypass)
			`CHK("rampUp", u0 + 1, upN)
			`CHK("rampDown", d0 + 1, dnN)
			`CHK("refEdge", r0 + 1, refN)
		end
	endtask

	task automatic run_abandon();
		int a0, n0, c;
		a0 = abN;
		n0 = rxCount;
		c = 0;
		testSwitch = 1'b1;
		repeat (4) @(negedge clk_sys);
		`CHK("pending", 1, testActive)
		while (abN == a0 && c < 200)
		begin
			@(negedge clk_sys);
			c++;
		end
		repeat (2) @(negedge clk_sys);
		`CHK("abandoned", a0 + 1, abN)
		`CHK("silent", n0, rxCount)
		`CHK("cleared", 0, testActive)
		testSwitch = 1'b0;
		repeat (4) @(negedge clk_sys);
	endtask

	task automatic run_test_burst();
		int n0, r0;
		n0 = rxCount;
		r0 = refN;
		slow = 1'b1;
		timeLock = 1'b1;
		repeat (4) @(negedge clk_sys);
		testSwitch = 1'b1;
		wait_n(n0 + 8, 8000);
		repeat (20) @(negedge clk_sys);
		`CHK("testCount", n0 + 8, rxCount)
		chk_burst(n0, 0, rx.logSlot[n0], 1'b1);
		`CHK("autoClear", 0, testActive)
		`CHK("refEdges", r0 + 8, refN)
		testSwitch = 1'b0;
		slow = 1'b0;
	endtask

	task automatic run_active();
		int n0, f, g, d;
		n0 = rxCount;
		posIn = P;
		posValid = 1'b1;
		@(negedge clk_sys);
		posValid = 1'b0;
		posIn = ~P;
		activeSwitch = 1'b1;
		wait_n(n0 + 72, 50000);
		`CHK("activeCount", n0 + 72, rxCount)
		f = int'(rx.logSlot[n0]);
		g = int'(rx.logSlot[n0+64]);
		for (int b = 0; b < 8; b++)
			chk_burst(n0 + 8 * b, 7 - b, f, 1'b0);
		chk_burst(n0 + 64, 7, g, 1'b0);
		d = (g + 2250 - f) % 2250;
		`CHK("offsetMsg", d, rx.logSub[n0+56])
		`CHK("offset", 1, int'(d >= 2025 || d <= 225))
		activeSwitch = 1'b0;
	endtask

	initial
	begin
		repeat (8) @(negedge clk_sys);
		rst_n = 1'b1;
		@(negedge clk_sys);
		frameStart = 1'b1;
		@(negedge clk_sys);
		frameStart = 1'b0;
		tickOn = 1'b1;
		repeat (4) @(negedge clk_sys);
		run_cw();
		run_patterns();
		run_abandon();
		run_test_burst();
		run_active();
		wrap_up();
	end

	// Longest path is about ten minutes of slots at two cycles each
	initial
	begin
		repeat (100000) @(posedge clk_sys);
		fails++;
		wrap_up();
	end
endmodule // tb
